// [core/vfs_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vfs_defines.svh"

module vfs_supervisor #(
	parameter int PHASE_DIV       = `VFS_PHASE_DIV_DEFAULT,
	parameter int PREPG_OC_TICKS  = `VFS_PREPG_OC_TICKS,
	parameter int OPEN_LOOP_TICKS = `VFS_OPEN_LOOP_TICKS,
	parameter int STARTUP_TICKS   = `VFS_CHAIN_STARTUP_TICKS
)(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       enable,
	input  wire logic       platform_power_ok,
	input  wire logic       supply_above_94,
	input  wire logic       supply_lockout,
	input  wire logic [1:0] ea_high,
	input  wire logic [1:0] overvoltage_trip,
	input  wire logic [1:0] under_315,
	input  wire logic [1:0] out_spec_high,
	input  wire logic [1:0] in_regulation,
	input  wire logic [1:0] ss_above_3v9,
	input  wire logic [1:0] over_current,
	input  wire logic [1:0] sense_below_200mv,
	input  wire logic [1:0] open_line_cmp,
	input  wire logic [1:0] err_over_50mv,
	input  wire logic [1:0] dvid_down,
	input  wire logic [1:0] transition_active,
	input  wire logic [1:0] voltage_code_valid,
	input  wire logic [6:0] voltage_code,
	input  wire logic       serial_voltage_data,
	input  wire logic       serial_voltage_clock,
	input  wire logic       phase_chain_in,
	output var  logic       power_good_out,
	output var  logic [1:0] error_amp_pulldown,
	output var  logic [1:0] softstart_discharge,
	output var  logic [1:0] softstart_charge_en,
	output var  logic       osc_overvoltage_pin,
	output var  logic [1:0] current_share_drive,
	output var  logic [1:0] sense_test_pulse,
	output var  logic [1:0] overvoltage_fixed_sel,
	output var  logic       regulate_to_boot,
	output var  logic [1:0] boot_code,
	output var  logic       phase_clock_out,
	output var  logic       phase_chain_out,
	output var  logic [5:0] phase_count,
	output var  logic       chain_fault,
	output var  logic       supply_fault,
	output var  logic [1:0] overvoltage_fault,
	output var  logic [1:0] open_sense_fault,
	output var  logic [1:0] open_loop_fault
);

	// refuse parameter values the counters cannot serve
	generate
		if (PHASE_DIV < 2 || PREPG_OC_TICKS < 2 || OPEN_LOOP_TICKS < 2)
		begin : g_bad_params
			$error("vfs_supervisor: divider or tick counts too small");
		end
	endgenerate

	localparam int PLANES = `VFS_PLANES;
	localparam int NF     = `VFS_FLAG_COUNT;
	localparam int DIVW   = $clog2(PHASE_DIV);
	localparam int OCW    = $clog2(PREPG_OC_TICKS);
	localparam int ELW    = $clog2(OPEN_LOOP_TICKS);

	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(PHASE_DIV - 1);
	localparam logic [DIVW-1:0] DIV_HALF = DIVW'(PHASE_DIV / 2);
	localparam logic [OCW-1:0]  OC_LAST  = OCW'(PREPG_OC_TICKS - 1);
	localparam logic [ELW-1:0]  EA_LAST  = ELW'(OPEN_LOOP_TICKS - 1);

	// comparator flags through a two stage synchroniser
	wire [NF-1:0] flag_raw = {enable, supply_above_94, supply_lockout, ea_high,
		overvoltage_trip, under_315, out_spec_high, in_regulation, ss_above_3v9,
		over_current, sense_below_200mv, open_line_cmp, err_over_50mv};
	logic [NF-1:0] sync_a;
	logic [NF-1:0] flag_s;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sync_a <= '0;
			flag_s <= '0;
		end
		else
		begin
			sync_a <= flag_raw;
			flag_s <= sync_a;
		end
	end

	// unpack the synchronised flags
	wire       en_s        = flag_s[22];
	wire       above94_s   = flag_s[21];
	wire       lockout_s   = flag_s[20];
	wire [1:0] ea_high_s   = flag_s[19:18];
	wire [1:0] ov_trip_s   = flag_s[17:16];
	wire [1:0] under_s     = flag_s[15:14];
	wire [1:0] spec_high_s = flag_s[13:12];
	wire [1:0] in_reg_s    = flag_s[11:10];
	wire [1:0] ss39_s      = flag_s[9:8];
	wire [1:0] oc_s        = flag_s[7:6];
	wire [1:0] below200_s  = flag_s[5:4];
	wire [1:0] open_line_s = flag_s[3:2];
	wire [1:0] err50_s     = flag_s[1:0];

	// phase clock divider, one-cycle tick per period
	logic [DIVW-1:0] div_cnt;
	logic            phase_tick;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			div_cnt         <= '0;
			phase_tick      <= 1'b0;
			phase_clock_out <= 1'b0;
		end
		else
		begin
			div_cnt         <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
			phase_tick      <= (div_cnt == DIV_LAST);
			phase_clock_out <= (div_cnt < DIV_HALF);
		end
	end

	// global state: enable edge, platform ok edge, supply latches
	logic en_q;
	logic platform_power_ok_q;
	logic supply_ok;
	logic ss_cleared;
	logic gen_fault;

	wire en_rise    = en_s && !en_q;
	wire platform_power_ok_fall = platform_power_ok_q && !platform_power_ok && en_s;
	wire boot_exit  = platform_power_ok && (|voltage_code_valid);
	wire [6:0] boot_voltage_code = `VFS_BOOT_CODE_BASE + {2'b00, boot_code, 3'b000};

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			en_q             <= 1'b0;
			platform_power_ok_q          <= 1'b0;
			supply_ok        <= 1'b0;
			ss_cleared       <= 1'b0;
			gen_fault        <= 1'b1;
			boot_code        <= 2'b00;
			regulate_to_boot <= 1'b0;
		end
		else
		begin
			en_q    <= en_s;
			platform_power_ok_q <= platform_power_ok;
			if (above94_s)
				supply_ok <= 1'b1;
			if (lockout_s)
				ss_cleared <= 1'b1;
			else if (en_rise)
				ss_cleared <= 1'b0;
			if (!en_s)
				gen_fault <= 1'b1;
			else if (en_rise)
				gen_fault <= 1'b0;
			if (en_rise)
				boot_code <= {serial_voltage_clock, serial_voltage_data};
			if (platform_power_ok_fall)
				regulate_to_boot <= 1'b1;
			else if (boot_exit)
				regulate_to_boot <= 1'b0;
		end
	end

	// per plane latches and counters
	logic [PLANES-1:0] ov_v;
	logic [PLANES-1:0] sense_v;
	logic [PLANES-1:0] loop_v;
	logic [PLANES-1:0] fixed_v;
	logic [PLANES-1:0] pg_kill;
	logic [PLANES-1:0] pg_ok;
	logic [PLANES-1:0] next_pulldown;
	logic [PLANES-1:0] next_discharge;
	logic [PLANES-1:0] next_charge;

	for (genvar p = 0; p < PLANES; p++)
	begin : g_plane
		logic [OCW-1:0]     oc_cnt;
		logic [ELW-1:0]     ea_cnt;
		logic               off_q;
		logic               ov_q;
		logic               sense_q;
		logic               loop_q;
		logic               oc_q;
		logic               fixed_q;
		logic               boot_up_q;
		vfs_pkg::vfs_code_t last_code;

		wire code_is_off = (voltage_code >= `VFS_OFF_CODE_LO);
		wire take_off    = voltage_code_valid[p] && code_is_off;
		wire take_on     = voltage_code_valid[p] && !code_is_off;
		wire oc_hit      = phase_tick && oc_s[p] && (oc_cnt == OC_LAST);
		wire ea_hit      = phase_tick && ea_high_s[p] && (ea_cnt == EA_LAST);
		wire masked      = transition_active[p] && !boot_up_q;

		always_ff @(posedge clock)
		begin
			if (rst)
			begin
				oc_cnt    <= '0;
				ea_cnt    <= '0;
				off_q     <= 1'b0;
				ov_q      <= 1'b0;
				sense_q   <= 1'b0;
				loop_q    <= 1'b0;
				oc_q      <= 1'b0;
				fixed_q   <= 1'b0;
				boot_up_q <= 1'b0;
				last_code <= `VFS_CODE_RESET;
			end
			else
			begin
				if (take_off)
					off_q <= 1'b1;
				else if (take_on)
					off_q <= 1'b0;
				if (take_on)
					last_code <= voltage_code;
				if (supply_ok && ov_trip_s[p])
					ov_q <= 1'b1;
				if (below200_s[p] && open_line_s[p])
					sense_q <= 1'b1;
				if (!ea_high_s[p])
					ea_cnt <= '0;
				else if (phase_tick && !ea_hit)
					ea_cnt <= ea_cnt + 1'b1;
				if (ea_hit)
					loop_q <= 1'b1;
				if (!oc_s[p] || power_good_out)
					oc_cnt <= '0;
				else if (phase_tick && !oc_hit)
					oc_cnt <= oc_cnt + 1'b1;
				if (oc_hit && !power_good_out)
					oc_q <= 1'b1;
				else if (en_rise)
					oc_q <= 1'b0;
				if (dvid_down[p] && err50_s[p])
					fixed_q <= 1'b1;
				else if (!err50_s[p])
					fixed_q <= 1'b0;
				if (platform_power_ok_fall)
					boot_up_q <= (boot_voltage_code < last_code);
				else if (boot_exit)
					boot_up_q <= 1'b0;
			end
		end

		// plane outputs and power good terms
		assign ov_v[p]    = ov_q;
		assign sense_v[p] = sense_q;
		assign loop_v[p]  = loop_q;
		assign fixed_v[p] = fixed_q;
		assign pg_ok[p]   = in_reg_s[p] && ss39_s[p];
		assign pg_kill[p] = (under_s[p] && !off_q && !masked)
			|| sense_q || loop_q || oc_q
			|| (boot_up_q && spec_high_s[p]);
		assign next_pulldown[p]  = off_q || ov_q || sense_q || loop_q || oc_q
			|| gen_fault;
		assign next_discharge[p] = off_q || sense_q || ss_cleared || gen_fault;
		assign next_charge[p]    = supply_ok && !gen_fault && !chain_fault && !off_q
			&& !ov_q && !sense_q && !loop_q && !oc_q && !ss_cleared;
	end

	// power good: latched once ready, dropped by any forcing condition
	wire force_low = !en_s || lockout_s || chain_fault || (|pg_kill);
	wire next_pg   = !force_low && (power_good_out || (&pg_ok));

	// registered outputs
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			power_good_out        <= 1'b0;
			error_amp_pulldown    <= 2'b11;
			softstart_discharge   <= 2'b11;
			softstart_charge_en   <= 2'b00;
			osc_overvoltage_pin   <= 1'b0;
			current_share_drive   <= 2'b00;
			sense_test_pulse      <= 2'b00;
			overvoltage_fixed_sel <= 2'b00;
			supply_fault          <= 1'b1;
			overvoltage_fault     <= 2'b00;
			open_sense_fault      <= 2'b00;
			open_loop_fault       <= 2'b00;
		end
		else
		begin
			power_good_out        <= next_pg;
			error_amp_pulldown    <= next_pulldown;
			softstart_discharge   <= next_discharge;
			softstart_charge_en   <= next_charge;
			osc_overvoltage_pin   <= |ov_v;
			current_share_drive   <= ov_v;
			sense_test_pulse      <= below200_s;
			overvoltage_fixed_sel <= fixed_v;
			supply_fault          <= !supply_ok;
			overvoltage_fault     <= ov_v;
			open_sense_fault      <= sense_v;
			open_loop_fault       <= loop_v;
		end
	end

	// phase daisy chain continuity and phase counting
	vfs_chain_check #(
		.STARTUP_TICKS   (STARTUP_TICKS)
	) u_chain (
		.clock           (clock),
		.rst             (rst),
		.phase_tick      (phase_tick),
		.phase_chain_in  (phase_chain_in),
		.phase_chain_out (phase_chain_out),
		.phase_count     (phase_count),
		.chain_fault     (chain_fault)
	);

endmodule : vfs_supervisor

`default_nettype wire

// [core/vfs_defines.svh]
`ifndef VFS_DEFINES_SVH
`define VFS_DEFINES_SVH

// plane count and clocking
`define VFS_PLANES              2
`define VFS_CLOCK_HZ            50000000
`define VFS_PHASE_DIV_DEFAULT   50

// voltage code layout: off range and boot code mapping
`define VFS_OFF_CODE_LO         7'h7C
`define VFS_CODE_RESET          7'h7F
`define VFS_BOOT_CODE_BASE      7'h24

// timing counts in phase clock ticks
`define VFS_PREPG_OC_TICKS      1024
`define VFS_OPEN_LOOP_TICKS     8
`define VFS_CHAIN_STARTUP_TICKS 32

// flag synchroniser layout: number of synchronised comparator flags
`define VFS_FLAG_COUNT          23

`endif

// [core/vfs_pkg.sv]
package vfs_pkg;

	// seven bit voltage code
	typedef logic [6:0] vfs_code_t;

	// phase daisy chain check states
	typedef enum logic [1:0] {
		CH_LAUNCH,
		CH_WAIT,
		CH_FAULT
	} vfs_chain_state_t;

endpackage : vfs_pkg

// [core/vfs_chain_check.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vfs_defines.svh"

module vfs_chain_check #(
	parameter int STARTUP_TICKS = `VFS_CHAIN_STARTUP_TICKS
)(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       phase_tick,
	input  wire logic       phase_chain_in,
	output var  logic       phase_chain_out,
	output var  logic [5:0] phase_count,
	output var  logic       chain_fault
);

	generate
		if (STARTUP_TICKS < 1 || STARTUP_TICKS > 63)
		begin : g_bad_ticks
			$error("vfs_chain_check: STARTUP_TICKS out of range");
		end
	endgenerate

	localparam logic [5:0] START_LIMIT = 6'(STARTUP_TICKS);

	vfs_pkg::vfs_chain_state_t state;
	logic       in_q;
	logic       counted;
	logic       missed;
	logic [5:0] cnt;

	// return edge and miss window: startup window first, then learned count
	wire       ret_edge = phase_chain_in && !in_q;
	wire [5:0] limit    = counted ? phase_count : START_LIMIT;
	wire       timeout  = phase_tick && (cnt >= limit);

	// launch, wait for return, retry once, then latch the fault
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state           <= vfs_pkg::CH_LAUNCH;
			in_q            <= 1'b0;
			counted         <= 1'b0;
			missed          <= 1'b0;
			cnt             <= 6'h00;
			phase_chain_out <= 1'b0;
			phase_count     <= 6'h00;
			chain_fault     <= 1'b0;
		end
		else
		begin
			in_q <= phase_chain_in;
			unique case (state)
				vfs_pkg::CH_LAUNCH:
				begin
					if (phase_tick)
					begin
						phase_chain_out <= 1'b1;
						cnt             <= 6'h00;
						state           <= vfs_pkg::CH_WAIT;
					end
				end
				vfs_pkg::CH_WAIT:
				begin
					if (phase_tick)
						phase_chain_out <= 1'b0;
					if (ret_edge)
					begin
						if (!counted)
						begin
							// phases from return timing
							phase_count <= (cnt == 6'h00) ? 6'h01 : cnt;
							counted     <= 1'b1;
						end
						missed <= 1'b0;
						state  <= vfs_pkg::CH_LAUNCH;
					end
					else if (timeout)
					begin
						if (missed)
						begin
							chain_fault <= 1'b1;
							state       <= vfs_pkg::CH_FAULT;
						end
						else
						begin
							missed <= 1'b1;
							state  <= vfs_pkg::CH_LAUNCH;
						end
					end
					else if (phase_tick)
						cnt <= cnt + 6'h01;
				end
				vfs_pkg::CH_FAULT:
				begin
					// cleared only by power-on reset
					chain_fault     <= 1'b1;
					phase_chain_out <= 1'b0;
				end
			endcase
		end
	end

endmodule : vfs_chain_check

`default_nettype wire

// [bench/vfs_sup_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module vfs_sup_assertions (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       enable,
	input wire logic [1:0] in_regulation,
	input wire logic [1:0] ss_above_3v9,
	input wire logic [1:0] voltage_code_valid,
	input wire logic [6:0] voltage_code,
	input wire logic [1:0] sense_below_200mv,
	input wire logic       power_good_out,
	input wire logic [1:0] error_amp_pulldown,
	input wire logic [1:0] softstart_discharge,
	input wire logic [1:0] softstart_charge_en,
	input wire logic       osc_overvoltage_pin,
	input wire logic [1:0] current_share_drive,
	input wire logic [1:0] sense_test_pulse,
	input wire logic       chain_fault,
	input wire logic [1:0] overvoltage_fault,
	input wire logic [1:0] open_sense_fault,
	input wire logic [1:0] open_loop_fault
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// sticky latches and good conditions
	wire logic [6:0] latches = {chain_fault, overvoltage_fault, open_sense_fault, open_loop_fault};
	wire logic       pg_terms = &in_regulation & &ss_above_3v9;
	a_ov_pulldown: assert property ((overvoltage_fault & ~error_amp_pulldown) == 2'h0)
		else $error("ov latch without pulldown");
	a_ov_signal: assert property (osc_overvoltage_pin == |overvoltage_fault
		&& current_share_drive == overvoltage_fault)
		else $error("ov signalling mismatch");
	a_latch_hold: assert property (($past(latches) & ~latches) == 7'h00)
		else $error("fault latch cleared without reset");
	a_enable_pg: assert property (!enable [*4] |=> !power_good_out)
		else $error("good high with enable low");
	a_pg_cause: assert property ($rose(power_good_out) |-> $past(pg_terms, 3))
		else $error("good rose before regulation and softstart");
	a_off_code: assert property (voltage_code_valid[0] && voltage_code >= 7'h7C
		|-> ##[2:3] error_amp_pulldown[0] && softstart_discharge[0])
		else $error("off code did not shut plane");
	a_sense_test: assert property (sense_test_pulse == $past(sense_below_200mv, 3))
		else $error("sense test pulse mismatch");
	a_os_shutdown: assert property ((open_sense_fault
		& ~(error_amp_pulldown & softstart_discharge)) == 2'h0)
		else $error("open sense without shutdown");
	a_chain_block: assert property (chain_fault |=> softstart_charge_en == 2'h0)
		else $error("charge allowed with chain fault");
	a_latch_pg: assert property (|{open_sense_fault, open_loop_fault} |=> !power_good_out)
		else $error("good high with latched fault");
endmodule : vfs_sup_assertions
`default_nettype wire

// [bench/vfs_phase_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vfs_phase_model #(
	parameter int DELAY = 2
)(
	input  wire logic       clock,
	input  wire logic       phase_clock_out,
	input  wire logic       phase_chain_out,
	input  wire logic [1:0] current_share_drive,
	input  wire logic       break_chain,
	output var  logic       phase_chain_in,
	output var  logic       low_side_on
);
	logic last_out = 1'b0;
	logic last_clk = 1'b0;
	int   left = 0;
	// chain return DELAY phase clocks after launch; broken chain stays low
	always @(posedge clock)
	begin
		last_out <= phase_chain_out;
		last_clk <= phase_clock_out;
		phase_chain_in <= 1'b0;
		if (phase_chain_out && !last_out && !break_chain)
			left <= DELAY;
		else if (left != 0 && phase_clock_out && !last_clk)
		begin
			left <= left - 1;
			phase_chain_in <= (left == 1);
		end
	end
	// low side clamp while share bus at rail
	assign #100 low_side_on = |current_share_drive;
endmodule : vfs_phase_model
`default_nettype wire

// [bench/vfs_supervisor_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module vfs_supervisor_tb_top;
	localparam int DIV = 4;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic enable, platform_power_ok, supply_above_94, supply_lockout;
	logic serial_voltage_data, serial_voltage_clock, break_chain;
	logic [1:0] ea_high, overvoltage_trip, under_315, out_spec_high, in_regulation;
	logic [1:0] ss_above_3v9, over_current, sense_below_200mv, open_line_cmp;
	logic [1:0] err_over_50mv, dvid_down, transition_active, voltage_code_valid;
	logic [6:0] voltage_code;
	wire logic phase_chain_in, low_side_on, power_good_out, osc_overvoltage_pin;
	wire logic regulate_to_boot, phase_clock_out, phase_chain_out, chain_fault, supply_fault;
	wire logic [1:0] error_amp_pulldown, softstart_discharge, softstart_charge_en;
	wire logic [1:0] current_share_drive, sense_test_pulse, overvoltage_fixed_sel, boot_code;
	wire logic [1:0] overvoltage_fault, open_sense_fault, open_loop_fault;
	wire logic [5:0] phase_count;
	int errors = 0;
	int num_checks = 0;
	int i;
	// 50 MHz clock
	always #10 clock = ~clock;
	vfs_supervisor #(.PHASE_DIV(DIV), .PREPG_OC_TICKS(8), .STARTUP_TICKS(4)) dut (.*);
	vfs_phase_model #(.DELAY(2)) u_phase (
		.clock(clock), .phase_clock_out(phase_clock_out), .phase_chain_out(phase_chain_out),
		.current_share_drive(current_share_drive), .break_chain(break_chain),
		.phase_chain_in(phase_chain_in), .low_side_on(low_side_on));
	// bench helpers
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic restart(input logic brk);
		{enable, platform_power_ok, supply_above_94, supply_lockout} = 4'h0;
		{serial_voltage_clock, serial_voltage_data} = 2'h2;
		{ea_high, overvoltage_trip, under_315, out_spec_high, in_regulation} = 10'h000;
		{ss_above_3v9, over_current, sense_below_200mv, open_line_cmp} = 8'h00;
		{err_over_50mv, dvid_down, transition_active, voltage_code_valid} = 8'h00;
		voltage_code = 7'h30;
		break_chain = brk;
		rst = 1'b1;
		step(6);
		rst = 1'b0;
	endtask : restart
	task automatic send_code(input logic [6:0] c);
		voltage_code = c;
		voltage_code_valid = 2'h1;
		step(1);
		voltage_code_valid = 2'h0;
		step(6);
	endtask : send_code
	task automatic wait_pg(input logic v);
		for (i = 0; i < 200 && power_good_out !== v; i++)
			step(1);
		check(power_good_out, v);
	endtask : wait_pg
	// main sequence
	initial
	begin
		restart(1'b0);
		check({supply_fault, power_good_out, error_amp_pulldown, softstart_discharge,
			softstart_charge_en}, 8'hBC);
		{supply_above_94, platform_power_ok, enable} = 3'h7;
		step(8);
		check(supply_fault, 1'b0);
		check(boot_code, 2'h2);
		in_regulation = 2'h3;
		step(20);
		check(power_good_out, 1'b0);
		ss_above_3v9 = 2'h3;
		wait_pg(1'b1);
		check(phase_count != 6'h00, 1'b1);
		check(softstart_charge_en, 2'h3);
		$display("test bring_up done");
		for (int c = 124; c < 128; c++)
		begin
			send_code(7'(c));
			check({error_amp_pulldown[0], softstart_discharge[0], power_good_out}, 3'h7);
			send_code(7'h2C);
			check(error_amp_pulldown[0], 1'b0);
		end
		$display("test off_codes done");
		under_315 = 2'h2;
		wait_pg(1'b0);
		check(error_amp_pulldown, 2'h0);
		under_315 = 2'h0;
		wait_pg(1'b1);
		{transition_active, under_315} = 4'hA;
		step(12);
		check(power_good_out, 1'b1);
		under_315 = 2'h0;
		step(6);
		transition_active = 2'h0;
		{dvid_down, err_over_50mv} = 4'hA;
		step(8);
		check(overvoltage_fixed_sel, 2'h2);
		err_over_50mv = 2'h0;
		step(8);
		check(overvoltage_fixed_sel, 2'h0);
		dvid_down = 2'h0;
		$display("test regulation done");
		send_code(7'h40);
		platform_power_ok = 1'b0;
		step(8);
		check(regulate_to_boot, 1'b1);
		out_spec_high = 2'h1;
		wait_pg(1'b0);
		out_spec_high = 2'h0;
		$display("test boot done");
		{sense_below_200mv, open_line_cmp} = 4'hB;
		step(8);
		check(sense_test_pulse, 2'h2);
		check({open_sense_fault, error_amp_pulldown[1], softstart_discharge[1]}, 4'hB);
		{sense_below_200mv, open_line_cmp} = 4'h0;
		overvoltage_trip = 2'h1;
		step(10);
		check({overvoltage_fault, current_share_drive, osc_overvoltage_pin, low_side_on},
			6'h17);
		overvoltage_trip = 2'h0;
		step(8);
		check({overvoltage_fault, open_sense_fault}, 4'h6);
		ea_high = 2'h1;
		step(7 * DIV);
		check(open_loop_fault, 2'h0);
		step(3 * DIV);
		check(open_loop_fault, 2'h1);
		$display("test latches done");
		restart(1'b0);
		{supply_above_94, platform_power_ok, enable} = 3'h7;
		{in_regulation, over_current} = 4'hD;
		step(12 * DIV);
		over_current = 2'h0;
		ss_above_3v9 = 2'h3;
		step(20);
		check({power_good_out, error_amp_pulldown}, 3'h1);
		check(softstart_discharge, 2'h0);
		supply_lockout = 1'b1;
		step(8);
		check(softstart_discharge, 2'h3);
		break_chain = 1'b1;
		step(16 * DIV);
		check(chain_fault, 1'b1);
		$display("test running faults done");
		restart(1'b1);
		check({overvoltage_fault, open_sense_fault, open_loop_fault}, 6'h00);
		{supply_above_94, enable} = 2'h3;
		for (i = 0; i < 400 && chain_fault !== 1'b1; i++)
			step(1);
		check({chain_fault, i >= 8 * DIV}, 2'h3);
		step(1);
		check(softstart_charge_en, 2'h0);
		$display("test chain done");
		wrap_up();
	end
	// hang guard
	initial
	begin
		#1_000_000;
		errors++;
		wrap_up();
	end
endmodule : vfs_supervisor_tb_top
bind vfs_supervisor vfs_sup_assertions u_chk (.*);
`default_nettype wire
